// ==== src/bsc_pkg.sv ====
// Constants and types for the board strap configuration logic
// Operation
// - While module DMA owns bus, drive snoop hi from segment 1, lo from 2
// - Switch segment ON reads as 0 on the snoop line, OFF as 1
// - First CPU type: 01 and 10 snoop, 00 and 11 snoop disabled
// - Second CPU type: 00 and 10 snoop enabled, 01 and 11 disabled
// - Segment 3 ON at start selects sticky reset mode, OFF legacy mode
// - Sticky mode: module reset only by software or power-up, never self-clear
// - Legacy mode: bit self-clears after 1 ms; bus reset also resets module
// - Segment 4 ON at start selects bit flash protect, OFF window scheme
// - Bit scheme: flash writes allowed while control bit is 1
// - Window scheme: access to upper window enables flash writes
// - Window scheme: access to lower window disables flash writes
// - ECC size from segments 1..3: 4, 8, 16, 32, 64 MB; segment 4 ignored
// - ECC model usable only when parity size switch is Off/Off/On
// - Factory ECC switch setting decodes to 16 MB
package bsc_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int RST_HOLD_NS = 1000000;
  localparam int RST_HOLD_CYC = RST_HOLD_NS / CLK_PERIOD_NS;
  localparam int TMR_W = 20;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_SW = 8'h08;
  localparam int CTRL_MRST = 0;
  localparam int CTRL_FWE = 1;
  localparam logic CTRL_MRST_RST = 1'h0;
  localparam logic CTRL_FWE_RST = 1'h0;
  localparam logic WIN_WE_RST = 1'h0;
  localparam int STAT_W = 9;
  localparam int SW_W = 10;

  // ----------------------------------------------------------------
  // Flash protect windows
  // ----------------------------------------------------------------
  localparam logic [31:0] WIN_EN_LO = 32'hfffcc000;
  localparam logic [31:0] WIN_EN_HI = 32'hfffcffff;
  localparam logic [31:0] WIN_DIS_LO = 32'hfffc8000;
  localparam logic [31:0] WIN_DIS_HI = 32'hfffcbfff;

  // ----------------------------------------------------------------
  // Switch patterns, bit set = segment ON, bit 0 = segment 1
  // ----------------------------------------------------------------
  localparam int SEG_STICKY = 2;
  localparam int SEG_BITFW = 3;
  localparam logic [2:0] ECC_PAT_4MB = 3'h7;
  localparam logic [2:0] ECC_PAT_8MB = 3'h3;
  localparam logic [2:0] ECC_PAT_16MB = 3'h5;
  localparam logic [2:0] ECC_PAT_32MB = 3'h1;
  localparam logic [2:0] ECC_PAT_64MB = 3'h6;
  localparam logic [2:0] PAR_PAT_OFF = 3'h4;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  localparam logic [2:0] ECC_NONE = 3'h0;
  localparam logic [2:0] ECC_4MB = 3'h1;
  localparam logic [2:0] ECC_8MB = 3'h2;
  localparam logic [2:0] ECC_16MB = 3'h3;
  localparam logic [2:0] ECC_32MB = 3'h4;
  localparam logic [2:0] ECC_64MB = 3'h5;
  localparam logic [1:0] SNP_SD_SINK = 2'h1;
  localparam logic [1:0] SNP_SD_INV = 2'h2;
  localparam logic [1:0] SNP_EN_A = 2'h0;
  localparam logic [1:0] SNP_EN_B = 2'h2;

  typedef enum logic {BSC_CAPTURE, BSC_RUN} bsc_state_t;

  typedef struct packed {
    logic module_reset;
    logic ecc_usable;
    logic [2:0] ecc_size;
    logic snoop_en;
    logic flash_we;
    logic bit_mode;
    logic sticky_mode;
  } bsc_status_t;

endpackage

// ==== src/bsc_reset_timer.sv ====
// Self-clear interval timer for the legacy module reset mode
`timescale 1ns/1ps
module bsc_reset_timer #(
  parameter int unsigned CYCLES = bsc_pkg::RST_HOLD_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic cancel,
  output logic done
);

  logic [bsc_pkg::TMR_W-1:0] count;
  logic running;
  wire logic last = running && (count == bsc_pkg::TMR_W'(CYCLES - 1));

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= '0;
      running <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= last && !start && !cancel;
      // A fresh start restarts the full interval
      if (start) begin
        count <= '0;
        running <= 1'b1;
      end else if (cancel || last) begin
        count <= '0;
        running <= 1'b0;
      end else if (running) begin
        count <= count + 1'b1;
      end
    end
  end

endmodule

// ==== src/bsc_top.sv ====
// Board strap configuration logic with APB register access
`timescale 1ns/1ps
module bsc_top #(
  parameter int unsigned RESET_HOLD_CYCLES = bsc_pkg::RST_HOLD_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic [3:0] misc_config_switch,
  input wire logic [3:0] ecc_size_switch,
  input wire logic [2:0] parity_size_switch,
  input wire logic cpu_second_type,
  input wire logic dma_bus_master,
  input wire logic lb_resetn,
  input wire logic lb_access,
  input wire logic [31:0] lb_addr,
  output logic snoop_ctl_hi,
  output logic snoop_ctl_lo,
  output logic snoop_ctl_oe,
  output logic snoop_request_en,
  output logic module_reset,
  output logic flash_write_enable,
  output logic [2:0] ecc_size,
  output logic ecc_usable
);

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic logic snoop_on(input logic [1:0] pair,
                                    input logic second);
    if (second) begin
      snoop_on = (pair == bsc_pkg::SNP_EN_A) ||
                 (pair == bsc_pkg::SNP_EN_B);
    end else begin
      snoop_on = (pair == bsc_pkg::SNP_SD_SINK) ||
                 (pair == bsc_pkg::SNP_SD_INV);
    end
  endfunction

  function automatic logic in_range(input logic [31:0] a,
                                    input logic [31:0] lo,
                                    input logic [31:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  bsc_pkg::bsc_state_t state;
  logic sticky_mode;
  logic bit_mode;
  logic ctrl_mrst;
  logic ctrl_fwe;
  logic win_we;
  logic tmr_done;

  // ----------------------------------------------------------------
  // Combinational decode
  // ----------------------------------------------------------------
  // ON segment drives logic 0 onto the line
  wire logic [1:0] snoop_pair = {~misc_config_switch[0],
                                 ~misc_config_switch[1]};
  wire logic next_snoop_en = snoop_on(snoop_pair, cpu_second_type);
  wire logic [2:0] ecc_pat = ecc_size_switch[2:0];
  wire logic [2:0] next_ecc_size =
    (ecc_pat == bsc_pkg::ECC_PAT_4MB) ? bsc_pkg::ECC_4MB :
    (ecc_pat == bsc_pkg::ECC_PAT_8MB) ? bsc_pkg::ECC_8MB :
    (ecc_pat == bsc_pkg::ECC_PAT_16MB) ? bsc_pkg::ECC_16MB :
    (ecc_pat == bsc_pkg::ECC_PAT_32MB) ? bsc_pkg::ECC_32MB :
    (ecc_pat == bsc_pkg::ECC_PAT_64MB) ? bsc_pkg::ECC_64MB :
    bsc_pkg::ECC_NONE;
  wire logic next_ecc_usable = (parity_size_switch == bsc_pkg::PAR_PAT_OFF)
                               && (next_ecc_size != bsc_pkg::ECC_NONE);

  wire logic hit_en = lb_access && in_range(lb_addr, bsc_pkg::WIN_EN_LO,
                                            bsc_pkg::WIN_EN_HI);
  wire logic hit_dis = lb_access && in_range(lb_addr, bsc_pkg::WIN_DIS_LO,
                                             bsc_pkg::WIN_DIS_HI);

  wire logic running = (state == bsc_pkg::BSC_RUN);
  wire logic apb_setup = psel && !penable && !pready;
  wire logic apb_done = psel && penable && pready;
  wire logic wr_ctrl = apb_done && pwrite && (paddr == bsc_pkg::ADDR_CTRL);
  wire logic mapped = (paddr == bsc_pkg::ADDR_CTRL) ||
                      (paddr == bsc_pkg::ADDR_STAT) ||
                      (paddr == bsc_pkg::ADDR_SW);
  wire logic wr_mrst = pwdata[bsc_pkg::CTRL_MRST];
  // Local bus reset only touches the module in legacy mode
  wire logic lb_rst_hit = running && !sticky_mode && !lb_resetn;
  wire logic tmr_start = wr_ctrl && wr_mrst && !ctrl_mrst && !sticky_mode;
  // Software write wins over the self-clear in the same cycle
  wire logic next_mrst = wr_ctrl ? wr_mrst :
                         (lb_rst_hit || (tmr_done && !sticky_mode)) ? 1'b0 :
                         ctrl_mrst;
  wire logic next_fwe = wr_ctrl ? pwdata[bsc_pkg::CTRL_FWE] : ctrl_fwe;
  // A window hit is an event: enable wins if both somehow hit
  wire logic next_win_we = hit_en ? 1'b1 :
                           hit_dis ? 1'b0 : win_we;
  wire logic next_flash_we = bit_mode ? next_fwe : next_win_we;

  bsc_pkg::bsc_status_t stat;
  assign stat = '{module_reset: module_reset, ecc_usable: ecc_usable,
                  ecc_size: ecc_size, snoop_en: snoop_request_en,
                  flash_we: flash_write_enable, bit_mode: bit_mode,
                  sticky_mode: sticky_mode};
  wire logic [31:0] next_rdata =
    (paddr == bsc_pkg::ADDR_CTRL) ? {30'h0, ctrl_fwe, ctrl_mrst} :
    (paddr == bsc_pkg::ADDR_STAT) ?
      {{(32-bsc_pkg::STAT_W){1'b0}}, stat} :
    (paddr == bsc_pkg::ADDR_SW) ?
      {22'h0, parity_size_switch, ecc_size_switch[2:0],
       misc_config_switch} :
    32'h0;

  // ----------------------------------------------------------------
  // Mode sampling at reset release
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= bsc_pkg::BSC_CAPTURE;
      sticky_mode <= 1'b1;
      bit_mode <= 1'b1;
    end else begin
      unique case (state)
        bsc_pkg::BSC_CAPTURE: begin
          sticky_mode <= misc_config_switch[bsc_pkg::SEG_STICKY];
          bit_mode <= misc_config_switch[bsc_pkg::SEG_BITFW];
          state <= bsc_pkg::BSC_RUN;
        end
        bsc_pkg::BSC_RUN: begin
          state <= bsc_pkg::BSC_RUN;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Control bits
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_mrst <= bsc_pkg::CTRL_MRST_RST;
      ctrl_fwe <= bsc_pkg::CTRL_FWE_RST;
      win_we <= bsc_pkg::WIN_WE_RST;
    end else begin
      ctrl_mrst <= next_mrst;
      ctrl_fwe <= next_fwe;
      win_we <= next_win_we;
    end
  end

  bsc_reset_timer #(
    .CYCLES(RESET_HOLD_CYCLES)
  ) u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .start(tmr_start),
    .cancel(wr_ctrl && !wr_mrst),
    .done(tmr_done)
  );

  // ----------------------------------------------------------------
  // APB slave, no wait states
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready <= apb_setup;
      prdata <= (apb_setup && !pwrite) ? next_rdata : 32'h0;
      pslverr <= apb_setup && !mapped;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Module reset held during power-up reset and for the capture cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      module_reset <= 1'b1;
      snoop_ctl_hi <= 1'b0;
      snoop_ctl_lo <= 1'b0;
      snoop_ctl_oe <= 1'b0;
      snoop_request_en <= 1'b0;
      flash_write_enable <= 1'b0;
      ecc_size <= bsc_pkg::ECC_NONE;
      ecc_usable <= 1'b0;
    end else begin
      module_reset <= !running || next_mrst || lb_rst_hit;
      snoop_ctl_hi <= dma_bus_master && snoop_pair[1];
      snoop_ctl_lo <= dma_bus_master && snoop_pair[0];
      snoop_ctl_oe <= dma_bus_master;
      snoop_request_en <= next_snoop_en;
      flash_write_enable <= running && next_flash_we;
      ecc_size <= next_ecc_size;
      ecc_usable <= next_ecc_usable;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_snoop_drive;
    @(posedge pclk) disable iff (!presetn)
    dma_bus_master |=> snoop_ctl_oe &&
      (snoop_ctl_hi == !$past(misc_config_switch[0])) &&
      (snoop_ctl_lo == !$past(misc_config_switch[1]));
  endproperty
  a_snoop_drive: assert property (p_snoop_drive)
    else $error("snoop lines not driven from switches");

  property p_snoop_on_zero;
    @(posedge pclk) disable iff (!presetn)
    (dma_bus_master && misc_config_switch[0]) |=> !snoop_ctl_hi;
  endproperty
  a_snoop_on_zero: assert property (p_snoop_on_zero)
    else $error("ON segment not driven as zero");

  property p_snoop_first;
    @(posedge pclk) disable iff (!presetn)
    (!cpu_second_type && (misc_config_switch[1:0] == 2'h3))
      |=> !snoop_request_en;
  endproperty
  a_snoop_first: assert property (p_snoop_first)
    else $error("first type snoop enabled for 00");

  property p_snoop_second;
    @(posedge pclk) disable iff (!presetn)
    (cpu_second_type && (misc_config_switch[1:0] == 2'h3))
      |=> snoop_request_en;
  endproperty
  a_snoop_second: assert property (p_snoop_second)
    else $error("second type snoop not enabled for 00");

  property p_mode_capture;
    @(posedge pclk) disable iff (!presetn)
    (state == bsc_pkg::BSC_CAPTURE) |=>
      (sticky_mode == $past(misc_config_switch[2])) &&
      (bit_mode == $past(misc_config_switch[3])) && $stable(state) == 1'b0;
  endproperty
  a_mode_capture: assert property (p_mode_capture)
    else $error("modes not sampled at reset release");

  property p_sticky_hold;
    @(posedge pclk) disable iff (!presetn)
    (running && sticky_mode && ctrl_mrst && !wr_ctrl) |=> ctrl_mrst;
  endproperty
  a_sticky_hold: assert property (p_sticky_hold)
    else $error("sticky reset bit cleared itself");

  property p_legacy_bus_reset;
    @(posedge pclk) disable iff (!presetn)
    (running && !sticky_mode && !lb_resetn) |=> module_reset;
  endproperty
  a_legacy_bus_reset: assert property (p_legacy_bus_reset)
    else $error("bus reset did not reset module");

  property p_bit_scheme;
    @(posedge pclk) disable iff (!presetn)
    (running && bit_mode && !wr_ctrl) |=>
      (flash_write_enable == $past(ctrl_fwe));
  endproperty
  a_bit_scheme: assert property (p_bit_scheme)
    else $error("flash enable does not follow control bit");

  property p_win_enable;
    @(posedge pclk) disable iff (!presetn)
    (running && !bit_mode && hit_en) |=> flash_write_enable;
  endproperty
  a_win_enable: assert property (p_win_enable)
    else $error("enable window did not enable flash");

  property p_win_disable;
    @(posedge pclk) disable iff (!presetn)
    (running && !bit_mode && hit_dis && !hit_en) |=> !flash_write_enable;
  endproperty
  a_win_disable: assert property (p_win_disable)
    else $error("disable window did not inhibit flash");

  property p_ecc_usable;
    @(posedge pclk) disable iff (!presetn)
    (parity_size_switch != bsc_pkg::PAR_PAT_OFF) |=> !ecc_usable;
  endproperty
  a_ecc_usable: assert property (p_ecc_usable)
    else $error("ECC usable with parity model on");

  property p_ecc_factory;
    @(posedge pclk) disable iff (!presetn)
    (ecc_size_switch[2:0] == bsc_pkg::ECC_PAT_16MB)
      |=> (ecc_size == bsc_pkg::ECC_16MB);
  endproperty
  a_ecc_factory: assert property (p_ecc_factory)
    else $error("factory ECC setting not 16MB");

  property p_self_clear;
    @(posedge pclk) disable iff (!presetn)
    tmr_done && !sticky_mode && !wr_ctrl |=> !ctrl_mrst;
  endproperty
  a_self_clear: assert property (p_self_clear)
    else $error("legacy reset bit did not self-clear");

endmodule

// ==== bench/bsc_lb_model.sv ====
// Local bus master model that issues single memory accesses
`timescale 1ns/1ps
module bsc_lb_model (
  input wire logic pclk,
  input wire logic go,
  input wire logic [31:0] addr,
  output logic lb_access,
  output logic [31:0] lb_addr
);
  initial begin
    lb_access = 1'b0;
    lb_addr = 32'h0;
  end
  // Idle address bus toggles so a stale address never looks valid
  always @(posedge pclk) begin
    lb_access <= go;
    lb_addr <= go ? addr : ~lb_addr;
  end
endmodule

// ==== bench/test_board_strap_config_logic.sv ====
// Self-checking bench for the board strap configuration logic
`timescale 1ns/1ps
module test_board_strap_config_logic;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  // Short self-clear interval keeps the run brief
  localparam int HOLD = 20;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] misc_config_switch = 4'h0;
  logic [3:0] ecc_size_switch = 4'h0;
  logic [2:0] parity_size_switch = 3'h0;
  logic cpu_second_type = 1'b0;
  logic dma_bus_master = 1'b0;
  logic lb_resetn = 1'b1;
  logic go = 1'b0;
  logic [31:0] go_addr = 32'h0;
  logic [31:0] prdata, lb_addr, rd;
  logic pready, pslverr, snoop_ctl_hi, snoop_ctl_lo, snoop_ctl_oe;
  logic snoop_request_en, module_reset, flash_write_enable, ecc_usable;
  logic lb_access, err;
  logic [2:0] ecc_size;
  int error_cnt = 0;
  int n_checks = 0;

  always #5 pclk = ~pclk;

  bsc_top #(.RESET_HOLD_CYCLES(HOLD)) bsc_top_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr),
    .misc_config_switch(misc_config_switch),
    .ecc_size_switch(ecc_size_switch),
    .parity_size_switch(parity_size_switch),
    .cpu_second_type(cpu_second_type), .dma_bus_master(dma_bus_master),
    .lb_resetn(lb_resetn), .lb_access(lb_access), .lb_addr(lb_addr),
    .snoop_ctl_hi(snoop_ctl_hi), .snoop_ctl_lo(snoop_ctl_lo),
    .snoop_ctl_oe(snoop_ctl_oe), .snoop_request_en(snoop_request_en),
    .module_reset(module_reset), .flash_write_enable(flash_write_enable),
    .ecc_size(ecc_size), .ecc_usable(ecc_usable));

  bsc_lb_model bsc_lb_model_i (.pclk(pclk), .go(go), .addr(go_addr),
    .lb_access(lb_access), .lb_addr(lb_addr));

  // ------------------------------------------------------------
  // Tasks and expectations
  // ------------------------------------------------------------
  task chk(input string name, input logic [31:0] exp,
           input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task finish_test;
    $display("errors %0d checks %0d", error_cnt, n_checks);
    if (error_cnt == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task tick(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask

  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i == 16) begin
      chk("pready wait", 32'h1, 32'h0);
      finish_test();
    end
  endtask

  task rst(input logic [3:0] m, input int n);
    @(posedge pclk);
    presetn <= 1'b0;
    misc_config_switch <= m;
    tick(n);
    chk("module_reset in reset", 32'h1, 32'(module_reset));
    @(posedge pclk);
    presetn <= 1'b1;
    tick(3);
  endtask

  task lbacc(input logic [31:0] a, input logic exp);
    @(posedge pclk);
    go <= 1'b1;
    go_addr <= a;
    @(posedge pclk);
    go <= 1'b0;
    tick(1);
    chk("flash_write_enable", 32'(exp), 32'(flash_write_enable));
  endtask

  task lbrst(input logic exp);
    @(posedge pclk);
    lb_resetn <= 1'b0;
    tick(1);
    chk("module_reset bus reset", 32'(exp), 32'(module_reset));
    @(posedge pclk);
    lb_resetn <= 1'b1;
  endtask

  // Segment pattern bit set = ON, bit 0 = segment 1
  function logic [2:0] ecc_exp(input logic [2:0] p);
    case (p)
      3'b111: return 3'h1;
      3'b011: return 3'h2;
      3'b101: return 3'h3;
      3'b001: return 3'h4;
      3'b110: return 3'h5;
      default: return 3'h0;
    endcase
  endfunction

  function logic snp_exp(input logic sec, input logic hi, input logic lo);
    return sec ? !lo : (hi ^ lo);
  endfunction

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial begin
    logic [31:0] v;
    logic [2:0] sz;
    logic [3:0] sn;
    void'($urandom(32'hed73));
    rst(4'b1100, 20);
    apb(1'b0, 8'h04, 32'h0);
    chk("status modes sticky bit", 32'h3, 32'(rd[1:0]));
    apb(1'b1, 8'h00, 32'h1);
    tick(HOLD + 10);
    chk("sticky module_reset", 32'h1, 32'(module_reset));
    apb(1'b1, 8'h00, 32'h2);
    tick(1);
    chk("sticky release", 32'h0, 32'(module_reset));
    chk("bit flash on", 32'h1, 32'(flash_write_enable));
    lbrst(1'b0);
    lbacc(32'hfffc8000, 1'b1);
    apb(1'b1, 8'h00, 32'h0);
    tick(1);
    chk("bit flash off", 32'h0, 32'(flash_write_enable));
    lbacc(32'hfffcc000, 1'b0);
    rst(4'b0000, 5);
    apb(1'b0, 8'h04, 32'h0);
    chk("status modes legacy win", 32'h0, 32'(rd[1:0]));
    apb(1'b1, 8'h00, 32'h1);
    // Bit and module reset drop together one edge after the done pulse
    tick(HOLD);
    chk("legacy held", 32'h1, 32'(module_reset));
    tick(1);
    chk("legacy self clear", 32'h0, 32'(module_reset));
    lbrst(1'b1);
    lbacc(32'hfffcffff, 1'b1);
    lbacc(32'hfffd0000, 1'b1);
    lbacc(32'hfffcbfff, 1'b0);
    lbacc(32'hfffcc000, 1'b1);
    lbacc(32'hfffc7fff, 1'b1);
    lbacc(32'hfffc8000, 1'b0);
    for (int i = 0; i < 24; i++) begin
      v = (i < 8) ? (32'(i) | 32'h8) : $urandom;
      sz = (i < 8) ? 3'(i) : v[6:4];
      @(posedge pclk);
      misc_config_switch[1:0] <= v[1:0];
      cpu_second_type <= v[2];
      dma_bus_master <= v[3];
      ecc_size_switch <= {v[7], sz};
      parity_size_switch <= v[8] ? 3'h4 : v[11:9];
      tick(1);
      // Request decode is checked whether or not the lines are driven
      sn = {v[3], v[3] & !v[0], v[3] & !v[1],
            snp_exp(v[2], !v[0], !v[1])};
      chk("snoop oe hi lo en", 32'(sn), 32'({snoop_ctl_oe, snoop_ctl_hi,
        snoop_ctl_lo, snoop_request_en}));
      chk("ecc size", 32'(ecc_exp(sz)), 32'(ecc_size));
      chk("ecc usable", 32'(parity_size_switch == 3'h4 && ecc_exp(sz) != 0),
        32'(ecc_usable));
    end
    apb(1'b0, 8'h08, 32'h0);
    chk("switch reg", {22'h0, parity_size_switch, ecc_size_switch[2:0],
      misc_config_switch}, rd);
    apb(1'b0, 8'h0c, 32'h0);
    chk("unmapped", 32'h1, {rd[30:0], err});
    finish_test();
  end
endmodule
